/* File: verilog/sdpc_pkg.sv */
// Purpose: shared constants and types of the sample clock divider and power control
// Assumes: one 50 MHz clock, register port decoded by the serial control port
// Notes: offsets are 8-bit register addresses
package sdpc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] PWR_MODE_ADDR = 8'h08;
    localparam logic [7:0] STAB_CTRL_ADDR = 8'h09;
    localparam logic [7:0] CLK_DIV_ADDR = 8'h0B;
    localparam logic [7:0] DIV_SYNC_ADDR = 8'h3A;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PM_LSB = 0;
    localparam int PM_MSB = 1;
    localparam int SYNC_EN_BIT = 1;
    localparam int SYNC_ONCE_BIT = 2;
    localparam int STAB_EN_BIT = 0;
    localparam int STAB_LOCK_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0] PWR_MODE_RST = 2'h0;
    localparam logic [1:0] DIV_SYNC_RST = 2'h0;
    localparam logic STAB_EN_RST = 1'b1;
    localparam logic [2:0] CLK_DIV_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // power-mode field codes
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_POWER_DOWN = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STAB_RELOCK_NS = 1500;
    localparam int STAB_RELOCK_CYC_I = (STAB_RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] STAB_RELOCK_CYC = 7'(STAB_RELOCK_CYC_I);

    ////////////////////////////////////////////////////////////////////////////
    // power state, one-hot
    typedef enum logic [2:0] {
        SDPC_RUN = 3'b001,
        SDPC_STANDBY = 3'b010,
        SDPC_POWER_DOWN = 3'b100
    } sdpc_pstate_t;

endpackage : sdpc_pkg

/* File: verilog/sdpc_sync2.sv */
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second
module sdpc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // two stages, reset low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : sdpc_sync2

/* File: verilog/sdpc_top.sv */
// Purpose: input clock divider with sync re-alignment, duty-cycle stabilizer
//          control and power-mode control
// Assumes: clk is the sample clock; the register port comes from the serial
//          control port decoder on the same clock
// Notes: the analog stabilizer is modelled as a shaping of the divided clock
//
// Summary of operation
// - The sample clock is divided by any integer from 1 to 8.
// - Ratios 1 and 2 give the same clock with the stabilizer on or off; ratio 4 does not.
// - Two divider-sync bits select re-alignment on every sync or only the first after a write.
// - A qualifying sync returns the divider to its initial count.
// - The sync pin is synchronised into the clock domain before use.
// - With the stabilizer active the divided clock is high half the period at even ratios; odd ratios from 3 get the shorter half.
// - The stabilizer does not lock while the clock rate is below about 20 MHz.
// - While unlocked the stabilizer is bypassed and the raw duty cycle shows.
// - Power-down is entered by the power-mode field or a high power-down pin.
// - In power-down the output drivers are released to high impedance.
// - A low power-down pin returns the device to the mode set by the power-mode field.
// - Power-down switches off reference, reference buffer, bias and clock.
// - Standby keeps the reference and the serial link running.
module sdpc_top
    import sdpc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic sync_pin,
    input wire logic power_down_pin,
    input wire logic clk_rate_low_pin,
    input wire logic clk_rate_change,
    output logic sample_en,
    output logic div_clk,
    output logic stabilizer_locked,
    output logic stabilizer_bypass,
    output logic out_drv_en,
    output logic ref_pwr_en,
    output logic bias_pwr_en,
    output logic int_clk_en,
    output logic link_run
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [2:0] high_len(input logic [2:0] sel);
        // high time in counts, half of sel plus one rounded down, at least one
        logic [3:0] r;
        r = {1'b0, sel} + 4'h1;
        high_len = (r[3:1] == 3'h0) ? 3'h1 : r[3:1];
    endfunction : high_len

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0] pmode_reg;
    logic [1:0] dsync_reg;
    logic stab_en_reg;
    logic [2:0] div_sel_reg;
    logic armed_reg;
    logic sync_d_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic sample_en_reg;
    logic div_clk_reg;
    logic [6:0] lock_cnt_reg;
    logic [6:0] lock_cnt_next;
    logic [7:0] rdata_reg;
    sdpc_pstate_t pstate_reg;
    sdpc_pstate_t pstate_next;
    logic [2:0] pins_s;
    logic sync_s;
    logic pd_pin_s;
    logic rate_low_s;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // sync, power-down and rate-low pin synchroniser
    sdpc_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({clk_rate_low_pin, power_down_pin, sync_pin}),
        .q(pins_s)
    );

    assign sync_s = pins_s[0];
    assign pd_pin_s = pins_s[1];
    assign rate_low_s = pins_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire pm_wr = reg_wr && (reg_addr == PWR_MODE_ADDR);
    wire stab_wr = reg_wr && (reg_addr == STAB_CTRL_ADDR);
    wire div_wr = reg_wr && (reg_addr == CLK_DIV_ADDR);
    wire dsync_wr = reg_wr && (reg_addr == DIV_SYNC_ADDR);
    wire sync_en = dsync_reg[0];
    wire sync_once = dsync_reg[1];

    // register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pmode_reg <= PWR_MODE_RST;
            dsync_reg <= DIV_SYNC_RST;
            stab_en_reg <= STAB_EN_RST;
            div_sel_reg <= CLK_DIV_RST;
        end else begin
            if (pm_wr) pmode_reg <= reg_wdata[PM_MSB:PM_LSB];
            if (dsync_wr) dsync_reg <= {reg_wdata[SYNC_ONCE_BIT], reg_wdata[SYNC_EN_BIT]};
            if (stab_wr) stab_en_reg <= reg_wdata[STAB_EN_BIT];
            if (div_wr) div_sel_reg <= reg_wdata[DIV_MSB:DIV_LSB];
        end
    end

    // read data, unmapped addresses read zero
    wire [7:0] rd_mux =
        (reg_addr == PWR_MODE_ADDR) ? {6'h00, pmode_reg} :
        (reg_addr == STAB_CTRL_ADDR) ? {stabilizer_locked, 6'h00, stab_en_reg} :
        (reg_addr == CLK_DIV_ADDR) ? {5'h00, div_sel_reg} :
        (reg_addr == DIV_SYNC_ADDR) ? {5'h00, dsync_reg, 1'b0} : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rdata_reg <= 8'h00;
        else if (reg_rd) rdata_reg <= rd_mux;
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // power state
    // power-down entry
    always_comb begin
        if (pd_pin_s || pmode_reg == PM_POWER_DOWN) pstate_next = SDPC_POWER_DOWN;
        else if (pmode_reg == PM_STANDBY) pstate_next = SDPC_STANDBY;
        else pstate_next = SDPC_RUN;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pstate_reg <= SDPC_RUN;
        else pstate_reg <= pstate_next;
    end

    wire pd_q = (pstate_reg == SDPC_POWER_DOWN);
    wire run_q = (pstate_reg == SDPC_RUN);
    assign out_drv_en = !pd_q;
    assign ref_pwr_en = !pd_q;
    assign link_run = !pd_q;
    assign int_clk_en = !pd_q;
    assign bias_pwr_en = run_q;

    ////////////////////////////////////////////////////////////////////////////
    // sync qualification
    wire sync_rise = sync_s && !sync_d_reg;
    wire sync_hit = sync_rise && sync_en && (!sync_once || armed_reg);

    // write arms the one-shot and wins over a same-cycle sync
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_d_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            sync_d_reg <= sync_s;
            if (dsync_wr) armed_reg <= 1'b1;
            else if (sync_hit) armed_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider
    // divide by sel plus one
    always_comb begin
        if (!run_q || sync_hit || cnt_reg >= div_sel_reg) cnt_next = 3'h0;
        else cnt_next = 3'(cnt_reg + 3'h1);
    end

    // ratios 1, 2 fine either way; ratio 4 is high one count in bypass, two shaped
    wire stab_active = stab_en_reg && stabilizer_locked;
    wire div_hi = stab_active ? (cnt_next < high_len(div_sel_reg)) : (cnt_next == 3'h0);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 3'h0;
            sample_en_reg <= 1'b0;
            div_clk_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sample_en_reg <= run_q && (cnt_next == 3'h0);
            div_clk_reg <= run_q && div_hi;
        end
    end

    assign sample_en = sample_en_reg;
    assign div_clk = div_clk_reg;
    assign stabilizer_bypass = !stab_active;

    ////////////////////////////////////////////////////////////////////////////
    // stabilizer lock model
    // no lock at low rate
    wire relock = clk_rate_change || div_wr || pd_q || !stab_en_reg || rate_low_s;

    always_comb begin
        if (relock) lock_cnt_next = 7'h00;
        else if (lock_cnt_reg == STAB_RELOCK_CYC) lock_cnt_next = lock_cnt_reg;
        else lock_cnt_next = 7'(lock_cnt_reg + 7'h01);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) lock_cnt_reg <= 7'h00;
        else lock_cnt_reg <= lock_cnt_next;
    end

    assign stabilizer_locked = (lock_cnt_reg == STAB_RELOCK_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    div_count_step_a: assert property (
        (run_q && !sync_hit && cnt_reg < div_sel_reg && $stable(div_sel_reg))
        |=> cnt_reg == 3'($past(cnt_reg) + 3'h1))
        else $error("divider count did not advance");
    div_wrap_a: assert property (
        (run_q && cnt_reg == div_sel_reg) |=> (cnt_reg == 3'h0 && sample_en))
        else $error("divider did not wrap at ratio");
    sync_realign_a: assert property (
        (sync_hit && run_q) |=> (cnt_reg == 3'h0 && sample_en))
        else $error("sync did not reset divider");
    sync_latency_a: assert property (
        sync_rise |-> ($past(sync_pin, 2) && !$past(sync_pin, 3)))
        else $error("sync not two stages late");
    sync_once_a: assert property (
        (sync_hit && sync_once && !dsync_wr) |=> !armed_reg)
        else $error("one-shot sync not disarmed");
    even_duty_a: assert property (
        (run_q && stab_active && sample_en && div_sel_reg == 3'h3 && dsync_reg == 2'h0
         && pmode_reg == PM_NORMAL && !pd_pin_s && !relock)
        |-> div_clk ##1 div_clk ##1 !div_clk)
        else $error("stabilized clock not even");
    low_rate_a: assert property (
        rate_low_s |=> !stabilizer_locked)
        else $error("lock while rate low");
    // a clock already shaped in the cycle the lock drops is excluded
    bypass_raw_a: assert property (
        (!stabilizer_locked && !$past(stabilizer_locked) && run_q && $past(run_q))
        |-> (div_clk == sample_en))
        else $error("bypass not following raw width");
    pd_entry_a: assert property (
        (pd_pin_s || pmode_reg == PM_POWER_DOWN) |=> (pd_q && !out_drv_en))
        else $error("power-down not entered");
    pd_off_a: assert property (
        pd_q |-> (!ref_pwr_en && !bias_pwr_en && !int_clk_en) ##1 !sample_en)
        else $error("power-down left blocks on");
    pin_release_a: assert property (
        ($fell(pd_pin_s) && pmode_reg == PM_NORMAL && !pm_wr) |=> run_q)
        else $error("pin low did not return to normal");
    standby_keep_a: assert property (
        (pstate_reg == SDPC_STANDBY) |-> (ref_pwr_en && link_run && out_drv_en && !bias_pwr_en))
        else $error("standby state wrong");
    mode_three_a: assert property (
        (!pd_pin_s && pmode_reg == 2'h3) |=> run_q)
        else $error("code 11 not normal");

    cover property (sync_hit && sync_once);
    cover property (pd_q ##1 run_q);
    cover property ($rose(stabilizer_locked));
    cover property (pstate_reg == SDPC_STANDBY);

endmodule : sdpc_top

/* File: verification/sdpc_sync_src.sv */
// Purpose: sync pulse driver standing in for the far-side sample clock source
// Assumes: fire is a one-cycle request from the bench
// Notes: the pin rises off the sampling edge, like an unaligned external source
module sdpc_sync_src (
    input wire logic clk,
    input wire logic fire,
    output logic sync_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold = 0;

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous sync level
    // raise on the falling edge and hold four cycles, well above the minimum spacing
    initial begin
        sync_pin = 1'b0;
        forever begin
            @(negedge clk);
            if (fire === 1'b1) begin
                hold = 4;
            end else if (hold > 0) begin
                hold--;
            end
            sync_pin = (hold > 0);
        end
    end
endmodule : sdpc_sync_src

/* File: verification/sample_clock_divider_power_control_tb.sv */
// Purpose: self-checking bench of the divider, stabilizer and power control
// Assumes: register strobes are one-cycle pulses on the 50 MHz clock
// Notes: every scenario task judges its own results
module sample_clock_divider_power_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdpc_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, sync_fire, sync_pin;
    logic power_down_pin, clk_rate_low_pin, clk_rate_change;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic sample_en, div_clk, stabilizer_locked, stabilizer_bypass;
    logic out_drv_en, ref_pwr_en, bias_pwr_en, int_clk_en, link_run;
    wire logic [4:0] pwr = {out_drv_en, ref_pwr_en, bias_pwr_en, int_clk_en, link_run};
    int fail_count = 0;
    int check_count = 0;

    sdpc_top i_sdpc_top (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sync_pin(sync_pin), .power_down_pin(power_down_pin),
        .clk_rate_low_pin(clk_rate_low_pin), .clk_rate_change(clk_rate_change),
        .sample_en(sample_en), .div_clk(div_clk), .stabilizer_locked(stabilizer_locked),
        .stabilizer_bypass(stabilizer_bypass), .out_drv_en(out_drv_en),
        .ref_pwr_en(ref_pwr_en),
        .bias_pwr_en(bias_pwr_en), .int_clk_en(int_clk_en), .link_run(link_run));
    sdpc_sync_src i_sdpc_sync_src (.clk(clk), .fire(sync_fire), .sync_pin(sync_pin));

    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // edges until the next sample pulse, bounded
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sample_en !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_pulse

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        logic [7:0] a [5] = '{PWR_MODE_ADDR, DIV_SYNC_ADDR, STAB_CTRL_ADDR, CLK_DIV_ADDR, 8'h55};
        logic [7:0] e [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(a[i], d);
            check("reset_reg", e[i], d);
        end
        check("reset_pwr", 8'h1F, 8'(pwr));
    endtask : t_reset

    // stabilizer stays enabled for every ratio, as the host must;
    // odd ratios from 3 keep the shorter half of the period high, ratio 1 stays high
    task automatic t_ratio;
        int n;
        int h;
        int p;
        for (int r = 1; r <= 8; r++) begin
            wr(CLK_DIV_ADDR, 8'(r - 1));
            repeat (100) @(posedge clk);
            wait_pulse(n);
            h = 0;
            p = 0;
            for (int k = 0; k < r; k++) begin
                h += (div_clk === 1'b1);
                p += (sample_en === 1'b1);
                @(posedge clk);
                #1;
            end
            check("div_high", 8'((r < 2) ? 1 : r / 2), 8'(h));
            check("pulses", 8'h01, 8'(p));
            check("period_end", 8'h01, 8'(sample_en));
        end
    endtask : t_ratio

    task automatic sync_try(input int exp);
        int n;
        wait_pulse(n);
        @(posedge clk);
        sync_fire <= 1'b1;
        @(posedge clk);
        sync_fire <= 1'b0;
        wait_pulse(n);
        check("sync_delay", 8'(exp), 8'(n));
    endtask : sync_try

    // ratio 8: a realign gives the pulse 2 edges on, no realign 6
    task automatic t_sync;
        wr(DIV_SYNC_ADDR, 8'h00);
        sync_try(6);
        wr(DIV_SYNC_ADDR, 8'h02);
        sync_try(2);
        sync_try(2);
        wr(DIV_SYNC_ADDR, 8'h06);
        sync_try(2);
        sync_try(6);
        wr(DIV_SYNC_ADDR, 8'h06);
        sync_try(2);
    endtask : t_sync

    task automatic t_lock;
        int n;
        logic [7:0] d;
        wr(CLK_DIV_ADDR, 8'h01);
        #1 n = 0;
        while (stabilizer_locked !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200) begin
            fail_count++;
            report_and_stop();
        end
        check("lock_time", 8'h01, 8'(n >= 70 && n <= 80));
        check("bypass_locked", 8'h00, 8'(stabilizer_bypass));
        rd(STAB_CTRL_ADDR, d);
        check("stab_reg", 8'h81, d);
        @(posedge clk);
        clk_rate_change <= 1'b1;
        @(posedge clk);
        clk_rate_change <= 1'b0;
        #1 check("bypass_change", 8'h01, 8'(stabilizer_bypass));
        @(posedge clk);
        clk_rate_low_pin <= 1'b1;
        repeat (120) @(posedge clk);
        #1 check("lock_low_rate", 8'h00, 8'(stabilizer_locked));
        @(posedge clk);
        clk_rate_low_pin <= 1'b0;
        wr(STAB_CTRL_ADDR, 8'h00);
        repeat (100) @(posedge clk);
        wait_pulse(n);
        check("bypass_off", 8'h01, 8'(stabilizer_bypass));
        check("raw_clk", 8'h01, 8'(div_clk));
        wait_pulse(n);
        check("ratio2_off", 8'h02, 8'(n));
        // ratio 4 in bypass: high for one count only, shaped it would be two
        wr(CLK_DIV_ADDR, 8'h03);
        wait_pulse(n);
        @(posedge clk);
        #1 check("raw_width", 8'h00, 8'(div_clk));
        wait_pulse(n);
        check("ratio4_off", 8'h03, 8'(n));
        wr(STAB_CTRL_ADDR, 8'h01);
    endtask : t_lock

    task automatic t_power;
        wr(PWR_MODE_ADDR, {6'h00, PM_POWER_DOWN});
        repeat (3) @(posedge clk);
        #1 check("pwr_down", 8'h00, 8'(pwr));
        wr(PWR_MODE_ADDR, {6'h00, PM_STANDBY});
        repeat (3) @(posedge clk);
        #1 check("pwr_standby", 8'h1B, 8'(pwr));
        wr(PWR_MODE_ADDR, 8'h03);
        repeat (3) @(posedge clk);
        #1 check("pwr_code3", 8'h1F, 8'(pwr));
        wr(PWR_MODE_ADDR, 8'h00);
        @(posedge clk);
        power_down_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check("pin_down", 8'h00, 8'(pwr));
        @(posedge clk);
        power_down_pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check("pin_up", 8'h1F, 8'(pwr));
    endtask : t_power

    ////////////////////////////////////////////////////////////////////////////
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, sync_fire, power_down_pin, clk_rate_low_pin} = 5'h00;
        clk_rate_change = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_ratio();
        t_sync();
        t_lock();
        t_power();
        report_and_stop();
    end
endmodule : sample_clock_divider_power_control_tb
